// ==== include/stb_pkg.sv ====
/*
  Constants for the sign-test branch and link unit: instruction fields,
  opcodes, sub-codes, widths and reset values.
  Assumes nothing of its surroundings; used by the unit and its decoder.
*/
`default_nettype none

package stb_pkg;

  // ==========================================================
  // Instruction fields
  localparam int OPC_HI = 31;
  localparam int OPC_LO = 26;
  localparam int SRC_HI = 25;
  localparam int SRC_LO = 21;
  localparam int SEC_HI = 20;
  localparam int SEC_LO = 16;
  localparam int OFS_HI = 15;
  localparam int OFS_LO = 0;
  localparam int OFS_SHIFT = 2;

  // ==========================================================
  // Opcodes and sub-codes
  localparam logic [5:0] OPC_REG_IMM = 6'h01;
  localparam logic [5:0] OPC_POSITIVE = 6'h07;
  localparam logic [4:0] SUB_NONNEG_NULLIFY = 5'h03;
  localparam logic [4:0] SUB_NONNEG_LINK = 5'h11;
  localparam logic [4:0] SUB_NONNEG_LINK_NULLIFY = 5'h13;
  localparam logic [4:0] SUB_POSITIVE = 5'h00;

  // ==========================================================
  // Link, widths and reset values
  localparam logic [4:0] LINK_REGISTER = 5'h1f;
  localparam logic [63:0] LINK_OFFSET = 64'h0000_0000_0000_0008;
  localparam int NARROW_SIGN = 31;
  localparam int WIDE_SIGN = 63;
  localparam logic [63:0] PC_RESET = 64'h0000_0000_0000_0000;

  // ==========================================================
  // Kinds of branch handled
  typedef enum logic [2:0] {
    STB_KIND_NONE = 3'b000,
    STB_KIND_NONNEG_LINK = 3'b001,
    STB_KIND_NONNEG_LINK_NULLIFY = 3'b010,
    STB_KIND_NONNEG_NULLIFY = 3'b011,
    STB_KIND_POSITIVE = 3'b100
  } stb_kind_t;

endpackage

`default_nettype wire

// ==== logic/stb_decode.sv ====
/*
  Decoder: classifies an instruction word into one of the sign-test branch
  kinds handled by the unit.
  Assumes a 32-bit instruction word from the same clock domain.
*/
`timescale 1ns/1ps
`default_nettype none

module stb_decode (
  input wire logic [31:0] instr,
  output var stb_pkg::stb_kind_t kind
);

  wire logic [5:0] opc = instr[stb_pkg::OPC_HI:stb_pkg::OPC_LO];
  wire logic [4:0] sec = instr[stb_pkg::SEC_HI:stb_pkg::SEC_LO];
  wire logic is_register_immediate_class = (opc == stb_pkg::OPC_REG_IMM);
  wire logic is_pos = (opc == stb_pkg::OPC_POSITIVE) && (sec == stb_pkg::SUB_POSITIVE);

  assign kind = is_pos ? stb_pkg::STB_KIND_POSITIVE :
                (is_register_immediate_class && sec == stb_pkg::SUB_NONNEG_LINK) ? stb_pkg::STB_KIND_NONNEG_LINK :
                (is_register_immediate_class && sec == stb_pkg::SUB_NONNEG_LINK_NULLIFY) ? stb_pkg::STB_KIND_NONNEG_LINK_NULLIFY :
                (is_register_immediate_class && sec == stb_pkg::SUB_NONNEG_NULLIFY) ? stb_pkg::STB_KIND_NONNEG_NULLIFY :
                stb_pkg::STB_KIND_NONE;

endmodule // stb_decode

`default_nettype wire

// ==== logic/stb_unit.sv ====
/*
  Sign-test branch and link unit: decodes the four sign-test branch forms,
  writes the link register, and steers the program counter after one delay
  slot or nullifies that slot for the likely forms.
  Assumes the pipeline presents one instruction per issue strobe, supplies
  the source register value, and issues the delay-slot instruction next.
  Assumes the mode input is settled in the issue cycle, that the source value
  is read before the link write of the same branch lands, and that the
  pipeline applies the nullify pulse to the slot it has just issued.
*/
// Summary of operation
// - Target is sign-extended offset shifted left two plus delay-slot address.
// - Primary opcode 000001 is the register-immediate class, sub-code in second field.
// - Sub-code 10011 is branch non-negative with link, nullify slot when not taken.
// - Non-negative branches take when sign bit clear: bit 31 or bit 63.
// - Linking forms always write instruction address plus 8 to register 31.
// - Taken branch redirects the counter after the one delay-slot instruction.
// - Linking nullify form discards the delay-slot instruction when not taken.
// - Sub-code 00011 is non-linking non-negative branch, nullify slot when not taken.
// - Positive branch, second field 00000, takes when sign clear and value non-zero.
// - These branches never raise an exception, even with register 31 as source.
// - Sub-code 10001 is branch non-negative with link, slot always executes.
`timescale 1ns/1ps
`default_nettype none

module stb_unit (
  input wire logic clock,
  input wire logic rst,
  input wire logic wide_mode,
  input wire logic issue,
  input wire logic [31:0] instr,
  input wire logic [63:0] instr_pc,
  input wire logic [63:0] src_value,
  input wire logic slot_issue,
  output logic is_branch,
  output logic link_we,
  output logic [4:0] link_addr,
  output logic [63:0] link_data,
  output logic redirect,
  output logic [63:0] redirect_pc,
  output logic nullify,
  output logic exception
);

  // ==========================================================
  // Functions

  // Folds a value to the width of the current mode; in narrow
  // mode the upper half repeats bit 31.
  function automatic logic [63:0] fit_mode(
    input logic wide,
    input logic [63:0] value
  );
    logic [63:0] folded;
    folded = {{32{value[stb_pkg::NARROW_SIGN]}}, value[31:0]};
    return wide ? value : folded;
  endfunction

  // Sign bit tested in the current mode.
  function automatic logic sign_of(
    input logic wide,
    input logic [63:0] value
  );
    logic bit_sel;
    bit_sel = wide ? value[stb_pkg::WIDE_SIGN] : value[stb_pkg::NARROW_SIGN];
    return bit_sel;
  endfunction

  // In narrow mode only the low word counts.
  function automatic logic zero_of(
    input logic wide,
    input logic [63:0] value
  );
    logic low_zero;
    logic high_zero;
    low_zero = (value[31:0] == 32'h0000_0000);
    high_zero = (value[63:32] == 32'h0000_0000);
    return wide ? (low_zero && high_zero) : low_zero;
  endfunction

  // True when the decoded form is the one wanted.
  function automatic logic kind_is(
    input stb_pkg::stb_kind_t kind_in,
    input stb_pkg::stb_kind_t wanted
  );
    return kind_in == wanted;
  endfunction

  // Forms that write the link register.
  function automatic logic kind_links(
    input stb_pkg::stb_kind_t kind_in
  );
    logic links;
    case (kind_in)
      stb_pkg::STB_KIND_NONNEG_LINK: links = 1'b1;
      stb_pkg::STB_KIND_NONNEG_LINK_NULLIFY: links = 1'b1;
      default: links = 1'b0;
    endcase
    return links;
  endfunction

  // Likely forms, whose slot is discarded when not taken.
  function automatic logic kind_discards(
    input stb_pkg::stb_kind_t kind_in
  );
    logic discards;
    case (kind_in)
      stb_pkg::STB_KIND_NONNEG_LINK_NULLIFY: discards = 1'b1;
      stb_pkg::STB_KIND_NONNEG_NULLIFY: discards = 1'b1;
      default: discards = 1'b0;
    endcase
    return discards;
  endfunction

  // ==========================================================
  // Decode
  stb_pkg::stb_kind_t kind;

  stb_decode u_decode (
    .instr(instr),
    .kind(kind)
  );

  // Only the four sign-test forms count as a hit; every other word is ignored.
  wire logic kind_none = kind_is(kind, stb_pkg::STB_KIND_NONE);
  wire logic kind_pos = kind_is(kind, stb_pkg::STB_KIND_POSITIVE);
  wire logic hit = issue && !kind_none;
  wire logic linking = kind_links(kind);
  wire logic likely = kind_discards(kind);

  // ==========================================================
  // Condition
  // The source is sampled at issue, before this branch's own link write lands,
  // so naming the link register as source changes nothing here.
  wire logic sign_bit = sign_of(wide_mode, src_value);
  wire logic src_zero = zero_of(wide_mode, src_value);
  wire logic cond_nonneg = !sign_bit;
  wire logic cond_pos = !sign_bit && !src_zero;
  wire logic cond = kind_pos ? cond_pos : cond_nonneg;

  // ==========================================================
  // Target
  wire logic [15:0] ofs = instr[stb_pkg::OFS_HI:stb_pkg::OFS_LO];
  wire logic [63:0] ofs_ext;

  assign ofs_ext[17:0] = {ofs, 2'b00};

  // The offset sign fills every bit above the shifted offset.
  for (genvar g = 18; g < 64; g++) begin : g_ofs_sign
    assign ofs_ext[g] = ofs[15];
  end

  wire logic [63:0] slot_pc = instr_pc + 64'h0000_0000_0000_0004;
  wire logic [63:0] sum = slot_pc + ofs_ext;
  // Narrow mode keeps a sign-extended 32-bit address.
  wire logic [63:0] target = fit_mode(wide_mode, sum);

  // ==========================================================
  // Link value
  // The link value is the address after the delay slot.
  wire logic [63:0] link_sum = instr_pc + stb_pkg::LINK_OFFSET;
  wire logic [63:0] link_val = fit_mode(wide_mode, link_sum);

  // ==========================================================
  // Slot tracking
  typedef enum logic [0:0] {
    STB_IDLE = 1'b0,
    STB_WAIT_SLOT = 1'b1
  } stb_slot_state_t;

  stb_slot_state_t state_ff;
  stb_slot_state_t nxt_state;

  // A branch issued while another waits for its slot replaces it.
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      STB_IDLE: begin
        if (hit) begin
          nxt_state = STB_WAIT_SLOT;
        end
      end
      STB_WAIT_SLOT: begin
        if (hit) begin
          nxt_state = STB_WAIT_SLOT;
        end else if (slot_issue) begin
          nxt_state = STB_IDLE;
        end
      end
      default: begin
        nxt_state = STB_IDLE;
      end
    endcase
  end

  wire logic pending = (state_ff == STB_WAIT_SLOT);
  wire logic slot_done = pending && slot_issue;

  // ==========================================================
  // Held outcome
  // Outcome and target are captured at issue and used when the slot issues.
  logic pend_taken_ff;
  logic [63:0] target_ff;
  logic link_we_ff;
  logic [63:0] link_data_ff;
  logic redirect_ff;
  logic [63:0] redirect_pc_ff;
  logic nullify_ff;

  wire logic slot_taken = slot_done && pend_taken_ff;
  wire logic nxt_pend_taken = hit ? cond : pend_taken_ff;
  wire logic [63:0] nxt_target = hit ? target : target_ff;
  // Written in the cycle after issue, taken or not.
  wire logic nxt_link_we = hit && linking;
  wire logic [63:0] nxt_link_data = nxt_link_we ? link_val : link_data_ff;
  wire logic nxt_redirect = slot_taken;
  wire logic [63:0] nxt_redirect_pc = slot_taken ? target_ff : redirect_pc_ff;
  // Reported one cycle after issue, without waiting for the slot.
  wire logic nxt_nullify = hit && likely && !cond;

  // ==========================================================
  // Registers
  // One register per process; every register clears on a synchronous reset.
  always_ff @(posedge clock) begin
    if (rst) begin
      state_ff <= STB_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      pend_taken_ff <= 1'b0;
    end else begin
      pend_taken_ff <= nxt_pend_taken;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      target_ff <= stb_pkg::PC_RESET;
    end else begin
      target_ff <= nxt_target;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      link_we_ff <= 1'b0;
    end else begin
      link_we_ff <= nxt_link_we;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      link_data_ff <= stb_pkg::PC_RESET;
    end else begin
      link_data_ff <= nxt_link_data;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      redirect_ff <= 1'b0;
    end else begin
      redirect_ff <= nxt_redirect;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      redirect_pc_ff <= stb_pkg::PC_RESET;
    end else begin
      redirect_pc_ff <= nxt_redirect_pc;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      nullify_ff <= 1'b0;
    end else begin
      nullify_ff <= nxt_nullify;
    end
  end

  // ==========================================================
  // Outputs
  // No condition of these branches can fault, so the exception output stays low.
  assign is_branch = hit;
  assign link_we = link_we_ff;
  assign link_addr = stb_pkg::LINK_REGISTER;
  assign link_data = link_data_ff;
  assign redirect = redirect_ff;
  assign redirect_pc = redirect_pc_ff;
  assign nullify = nullify_ff;
  assign exception = 1'b0;

endmodule // stb_unit

`default_nettype wire

// ==== bench/stb_properties.sv ====
/* Concurrent checks on the ports of the sign-test branch unit.
   Assumes it is bound to stb_unit and shares its clock and reset. */
`timescale 1ns/1ps
`default_nettype none
module stb_properties (
  input wire logic clock,
  input wire logic rst,
  input wire logic wide_mode,
  input wire logic issue,
  input wire logic [31:0] instr,
  input wire logic [63:0] instr_pc,
  input wire logic [63:0] src_value,
  input wire logic slot_issue,
  input wire logic is_branch,
  input wire logic link_we,
  input wire logic [4:0] link_addr,
  input wire logic [63:0] link_data,
  input wire logic redirect,
  input wire logic [63:0] redirect_pc,
  input wire logic nullify,
  input wire logic exception
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  wire logic [4:0] sub = instr[20:16];
  wire logic ri = issue && instr[31:26] == stb_pkg::OPC_REG_IMM;
  wire logic lnk = ri && (sub == stb_pkg::SUB_NONNEG_LINK || sub == stb_pkg::SUB_NONNEG_LINK_NULLIFY);
  wire logic neg = wide_mode ? src_value[63] : src_value[31];
  wire logic pos = issue && instr[31:26] == stb_pkg::OPC_POSITIVE && sub == 5'h00;
  // ==========================================================
  // Checks
  property p_exc; exception == 1'b0; endproperty
  a_exc: assert property (p_exc) else $error("exception raised");
  property p_addr; link_we |-> link_addr == stb_pkg::LINK_REGISTER; endproperty
  a_addr: assert property (p_addr) else $error("link address wrong");
  property p_link; lnk |=> link_we; endproperty
  a_link: assert property (p_link) else $error("link write missing");
  property p_ldata; lnk && wide_mode |=> link_data == $past(instr_pc) + stb_pkg::LINK_OFFSET; endproperty
  a_ldata: assert property (p_ldata) else $error("link data wrong");
  property p_null; ri && (sub == 5'h13 || sub == 5'h03) && neg |=> nullify; endproperty
  a_null: assert property (p_null) else $error("slot not discarded");
  property p_keep; (ri && sub == 5'h11) || pos |=> !nullify; endproperty
  a_keep: assert property (p_keep) else $error("slot discarded");
  property p_slot; redirect |-> $past(slot_issue); endproperty
  a_slot: assert property (p_slot) else $error("redirect before slot");
  property p_zero; pos && src_value == 64'h0 ##1 slot_issue |=> !redirect; endproperty
  a_zero: assert property (p_zero) else $error("zero source taken");
  property p_take; ri && sub == 5'h11 && !neg ##1 slot_issue |=> redirect; endproperty
  a_take: assert property (p_take) else $error("branch not taken");
  c_red: cover property (redirect);
  c_null: cover property (nullify);
  c_link: cover property (link_we);
endmodule // stb_properties
`default_nettype wire

// ==== bench/testbench.sv ====
/* Directed bench for the sign-test branch unit.
   Assumes stb_unit and stb_pkg are compiled first. */
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic wide_mode = 1'b0;
  logic issue = 1'b0;
  logic [31:0] instr = 32'h0;
  logic [63:0] instr_pc = 64'h0;
  logic [63:0] src_value = 64'h0;
  logic slot_issue = 1'b0;
  logic is_branch, link_we, redirect, nullify, exception;
  logic [4:0] link_addr;
  logic [63:0] link_data, redirect_pc;
  int miscompares = 0;
  int total_checks = 0;
  always #25 clock = ~clock;
  stb_unit dut (.clock(clock), .rst(rst), .wide_mode(wide_mode), .issue(issue), .instr(instr),
    .instr_pc(instr_pc), .src_value(src_value), .slot_issue(slot_issue), .is_branch(is_branch),
    .link_we(link_we), .link_addr(link_addr), .link_data(link_data), .redirect(redirect),
    .redirect_pc(redirect_pc), .nullify(nullify), .exception(exception));
  task automatic conclude();
    if (miscompares == 0 && total_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(string n, logic [63:0] e, logic [63:0] s);
    total_checks++;
    if (s !== e) begin
      miscompares++;
      $display("unexpected %s expected %h seen %h", n, e, s);
    end
  endtask
  // One branch, then its delay slot; b l nl tk give the expected outcome.
  task automatic br(logic [31:0] i, logic [63:0] pc, logic [63:0] s, logic w, logic b, logic l, logic nl, logic tk);
    logic [63:0] e_link;
    logic [63:0] e_tgt;
    e_link = pc + 64'h8;
    e_tgt = pc + 64'h4 + {{46{i[15]}}, i[15:0], 2'b00};
    // Narrow mode keeps addresses as sign-extended 32-bit values.
    if (!w) begin
      e_link = {{32{e_link[31]}}, e_link[31:0]};
      e_tgt = {{32{e_tgt[31]}}, e_tgt[31:0]};
    end
    @(negedge clock);
    issue = 1'b1;
    instr = i;
    instr_pc = pc;
    src_value = s;
    wide_mode = w;
    #1 chk("is_branch", b, is_branch);
    @(negedge clock);
    issue = 1'b0;
    slot_issue = 1'b1;
    chk("link_we", l, link_we);
    chk("nullify", nl, nullify);
    chk("exception", 64'h0, exception);
    if (l) chk("link_data", e_link, link_data);
    if (l) chk("link_addr", 64'h1f, link_addr);
    @(negedge clock);
    slot_issue = 1'b0;
    chk("redirect", tk, redirect);
    if (tk) chk("redirect_pc", e_tgt, redirect_pc);
  endtask
  task automatic t_link();
    logic [31:0] i;
    i = {stb_pkg::OPC_REG_IMM, 5'h1f, stb_pkg::SUB_NONNEG_LINK, 16'hfffe};
    br(i, 64'h1000, 64'h8000_0000, 1, 1, 1, 0, 1);
    br(i, 64'h1000, 64'h8000_0000, 0, 1, 1, 0, 0);
    br(i, 64'h1_0000_0000, 64'h0, 1, 1, 1, 0, 1);
  endtask
  task automatic t_nullify();
    logic [31:0] i;
    i = {stb_pkg::OPC_REG_IMM, 5'h2, stb_pkg::SUB_NONNEG_LINK_NULLIFY, 16'h0010};
    br(i, 64'h2000, 64'hffff_ffff_ffff_ffff, 1, 1, 1, 1, 0);
    br(i, 64'h2000, 64'h7fff_ffff, 0, 1, 1, 0, 1);
    br(i, 64'h7fff_fff8, 64'h1, 0, 1, 1, 0, 1);
    i = {stb_pkg::OPC_REG_IMM, 5'h2, stb_pkg::SUB_NONNEG_NULLIFY, 16'h8000};
    br(i, 64'h40000, 64'h8000_0000, 0, 1, 0, 1, 0);
    br(i, 64'h40000, 64'h1, 1, 1, 0, 0, 1);
  endtask
  task automatic t_positive();
    logic [31:0] i;
    i = {stb_pkg::OPC_POSITIVE, 5'h3, 5'h00, 16'h0004};
    br(i, 64'h3000, 64'h0, 1, 1, 0, 0, 0);
    br(i, 64'h3000, 64'h1, 0, 1, 0, 0, 1);
    br(i, 64'h3000, 64'h8000_0000_0000_0000, 1, 1, 0, 0, 0);
    br({stb_pkg::OPC_POSITIVE, 5'h3, 5'h01, 16'h0004}, 64'h3000, 64'h1, 0, 0, 0, 0, 0);
    br({stb_pkg::OPC_REG_IMM, 5'h3, 5'h01, 16'h0004}, 64'h3000, 64'h1, 0, 0, 0, 0, 0);
    br({6'h21, 5'h3, 5'h11, 16'h0004}, 64'h3000, 64'h1, 0, 0, 0, 0, 0);
  endtask
  initial begin
    repeat (8) @(negedge clock);
    rst = 1'b0;
    chk("redirect", 64'h0, redirect);
    chk("nullify", 64'h0, nullify);
    t_link();
    t_nullify();
    t_positive();
    conclude();
  end
  initial begin
    repeat (400) @(posedge clock);
    miscompares++;
    conclude();
  end
endmodule // testbench
bind stb_unit stb_properties u_props (.clock(clock), .rst(rst), .wide_mode(wide_mode), .issue(issue),
  .instr(instr), .instr_pc(instr_pc), .src_value(src_value), .slot_issue(slot_issue), .is_branch(is_branch),
  .link_we(link_we), .link_addr(link_addr), .link_data(link_data), .redirect(redirect),
  .redirect_pc(redirect_pc), .nullify(nullify), .exception(exception));
`default_nettype wire
